/* rtl/pbl_pkg.sv */
// Package with timing constants for the pushbutton on/off latch
package pbl_pkg;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned CNT_W = 28;
  localparam int unsigned DEBOUNCE_INTERVAL_A_US = 50000;
  localparam int unsigned DEBOUNCE_INTERVAL_B_US = 2000000;
  localparam int unsigned SHUTDOWN_HOLD_A_US = 8000000;
  localparam int unsigned SHUTDOWN_HOLD_B_US = 16000000;
  localparam int unsigned NOTIFY_PULSE_INTERVAL_US = 32000;
  localparam int unsigned NOTIFY_LONG_FACTOR = 4;
  localparam int unsigned FORCE_IGNORE_FACTOR = 2;
  localparam int unsigned GLITCH_WINDOW_US = 600;
  localparam int unsigned DEBOUNCE_INTERVAL_A_CYC = DEBOUNCE_INTERVAL_A_US * CLK_MHZ;
  localparam int unsigned DEBOUNCE_INTERVAL_B_CYC = DEBOUNCE_INTERVAL_B_US * CLK_MHZ;
  localparam int unsigned SHUTDOWN_HOLD_A_CYC = SHUTDOWN_HOLD_A_US * CLK_MHZ;
  localparam int unsigned SHUTDOWN_HOLD_B_CYC = SHUTDOWN_HOLD_B_US * CLK_MHZ;
  localparam int unsigned NOTIFY_PULSE_INTERVAL_CYC = NOTIFY_PULSE_INTERVAL_US * CLK_MHZ;
  localparam int unsigned GLITCH_WINDOW_CYC = GLITCH_WINDOW_US * CLK_MHZ;
  localparam logic POWER_EN_RESET = 1'b0;
  localparam logic PIN_IDLE_LEVEL = 1'b1;
endpackage

/* rtl/pbl_sync3.sv */
// Three-stage input synchroniser with agreement check
`timescale 1ns/100ps
module pbl_sync3
  import pbl_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;

  always_comb
  begin
    lvl_d = lvl_q;
    if (s2_q == s3_q)
    begin
      lvl_d = s3_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
      lvl_q <= RESET_LEVEL;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;
endmodule // pbl_sync3

/* rtl/pbl_onoff_latch.sv */
// Pushbutton on/off latch with debouncer, notify pulse and force-off input
// Function
// R1: Button held low past debounce interval latches power enable high.
// R2: Low force-off input clears power enable outside its ignore windows.
// R3: Variant A: holding button past 8s shutdown hold clears power enable.
// R4: Variant B: 16s hold keeps power enable, gives lengthened notify pulse.
// R5: Each debounced press starts one 32ms active-low notify pulse.
// R6: Press past shutdown hold gives 128ms notify pulse in both variants.
// R7: Holding past lengthened pulse never retriggers or extends notify.
// R8: Force-off input is ignored while power enable is low.
// R9: Force-off stays ignored for twice notify interval after power enable rises.
// R10: High glitches shorter than about 600us do not restart debounce timing.
// R11: A release longer than the glitch window resets debounce and hold timers.
// R12: Power-up state is arbitrary; system sets it by press or force-off.
// R13: Notify output is active-low open drain, released when not asserted.
// R14: Button input reads released when idle or unconnected.
// R15: Force-off low while power enable is low leaves it unchanged.
// R16: All intervals come from counters on one time base; debounce and shutdown hold are chosen by variant.
`timescale 1ns/100ps
module pbl_onoff_latch
  import pbl_pkg::*;
#(
  parameter bit VARIANT_B = 1'b0,
  parameter int unsigned DEBOUNCE_CYC = VARIANT_B ? DEBOUNCE_INTERVAL_B_CYC : DEBOUNCE_INTERVAL_A_CYC,
  parameter int unsigned SHUTDOWN_CYC = VARIANT_B ? SHUTDOWN_HOLD_B_CYC : SHUTDOWN_HOLD_A_CYC,
  parameter int unsigned NOTIFY_CYC = NOTIFY_PULSE_INTERVAL_CYC,
  parameter int unsigned GLITCH_CYC = GLITCH_WINDOW_CYC
)
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic BUTTON_IN_N,
  input wire logic FORCE_OFF_N,
  output logic POWER_EN,
  output logic NOTIFY_N_O,
  output logic NOTIFY_N_OE
);
  localparam logic [CNT_W-1:0] DB_L = CNT_W'(DEBOUNCE_CYC);
  localparam logic [CNT_W-1:0] SO_L = CNT_W'(SHUTDOWN_CYC);
  localparam logic [CNT_W-1:0] NT_L = CNT_W'(NOTIFY_CYC);
  localparam logic [CNT_W-1:0] NT_LONG_L = CNT_W'(NOTIFY_CYC * NOTIFY_LONG_FACTOR);
  localparam logic [CNT_W-1:0] IGN_L = CNT_W'(NOTIFY_CYC * FORCE_IGNORE_FACTOR);
  localparam logic [CNT_W-1:0] GL_L = CNT_W'(GLITCH_CYC);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  logic rst_s1_q;
  logic rst_n_q;
  logic btn_lvl;
  logic force_lvl;
  logic pressed_q;
  logic pressed_d;
  logic [CNT_W-1:0] hi_cnt_q;
  logic [CNT_W-1:0] hi_cnt_d;
  logic [CNT_W-1:0] press_cnt_q;
  logic [CNT_W-1:0] press_cnt_d;
  logic [CNT_W-1:0] notify_cnt_q;
  logic [CNT_W-1:0] notify_cnt_d;
  logic [CNT_W-1:0] ign_cnt_q;
  logic [CNT_W-1:0] ign_cnt_d;
  logic power_q;
  logic power_d;
  logic notify_q;
  logic notify_d;
  logic deb_evt;
  logic so_evt;
  logic force_hit;

  // Reset release through two flip-flops
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Idle level released means not pressed
  pbl_sync3 #(.RESET_LEVEL(PIN_IDLE_LEVEL)) u_btn_sync ( // R14
    .clk(CLK),
    .rst_n(rst_n_q),
    .pin_in(BUTTON_IN_N),
    .level_out(btn_lvl)
  );

  pbl_sync3 #(.RESET_LEVEL(PIN_IDLE_LEVEL)) u_force_sync (
    .clk(CLK),
    .rst_n(rst_n_q),
    .pin_in(FORCE_OFF_N),
    .level_out(force_lvl)
  );

  // Press tracking, glitch filter and interval timers
  assign deb_evt = pressed_q && (press_cnt_q == DB_L - ONE); // R1 R16
  assign so_evt = pressed_q && (press_cnt_q == SO_L - ONE); // R16
  assign force_hit = power_q && (ign_cnt_q == '0) && !force_lvl; // R2 R8 R9

  always_comb
  begin
    pressed_d = pressed_q;
    hi_cnt_d = hi_cnt_q;
    press_cnt_d = press_cnt_q;
    if (!btn_lvl)
    begin
      pressed_d = 1'b1;
      hi_cnt_d = '0;
    end
    else if (pressed_q)
    begin
      hi_cnt_d = hi_cnt_q + ONE; // R10
      if (hi_cnt_q >= GL_L - ONE)
      begin
        pressed_d = 1'b0; // R11
        hi_cnt_d = '0;
      end
    end
    if (!pressed_q)
    begin
      press_cnt_d = '0; // R11
    end
    else if (press_cnt_q < SO_L)
    begin
      press_cnt_d = press_cnt_q + ONE; // R7
    end
  end

  // Latch, ignore window and notify pulse
  always_comb
  begin
    power_d = power_q;
    ign_cnt_d = ign_cnt_q;
    notify_cnt_d = notify_cnt_q;
    if (ign_cnt_q != '0)
    begin
      ign_cnt_d = ign_cnt_q - ONE;
    end
    if (notify_cnt_q != '0)
    begin
      notify_cnt_d = notify_cnt_q - ONE;
    end
    if (force_hit)
    begin
      power_d = 1'b0; // R2 R15
    end
    if (so_evt && !VARIANT_B)
    begin
      power_d = 1'b0; // R3
    end
    if (deb_evt)
    begin
      power_d = 1'b1; // R1
      notify_cnt_d = NT_L; // R5
      if (!power_q)
      begin
        ign_cnt_d = IGN_L; // R9
      end
    end
    if (so_evt)
    begin
      notify_cnt_d = NT_LONG_L; // R4 R6
    end
    notify_d = (notify_cnt_d != '0);
  end

  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pressed_q <= 1'b0;
      hi_cnt_q <= '0;
      press_cnt_q <= '0;
      power_q <= POWER_EN_RESET; // R12
      ign_cnt_q <= '0;
      notify_cnt_q <= '0;
      notify_q <= 1'b0;
    end
    else
    begin
      pressed_q <= pressed_d;
      hi_cnt_q <= hi_cnt_d;
      press_cnt_q <= press_cnt_d;
      power_q <= power_d;
      ign_cnt_q <= ign_cnt_d;
      notify_cnt_q <= notify_cnt_d;
      notify_q <= notify_d;
    end
  end

  assign POWER_EN = power_q;
  assign NOTIFY_N_O = 1'b0; // R13
  assign NOTIFY_N_OE = notify_q; // R13

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_q);

  a_debounce_sets_power: assert property (deb_evt |=> power_q) else $error("power enable not set after debounce"); // R1
  a_force_clears_power: assert property (force_hit && !deb_evt |=> !power_q) else $error("force-off did not clear"); // R2
  a_hold_clears_a: assert property (so_evt && !VARIANT_B |=> !power_q) else $error("hold did not clear power"); // R3
  a_hold_keeps_b: assert property (so_evt && VARIANT_B && power_q |=> power_q) else $error("hold cleared power"); // R4
  a_notify_start_len: assert property (deb_evt |=> notify_q && notify_cnt_q == NT_L) else $error("bad notify start"); // R5
  a_notify_long_len: assert property (so_evt |=> notify_q && notify_cnt_q == NT_LONG_L) else $error("bad long notify"); // R6
  a_no_retrigger: assert property (pressed_q && press_cnt_q == SO_L && !notify_q |=> !notify_q) // R7
    else $error("notify retriggered");
  a_off_stays_off: assert property (!power_q && !deb_evt |=> !power_q) else $error("power rose without press"); // R8
  a_ignore_window: assert property ($rose(power_q) |-> ign_cnt_q == IGN_L - ONE || ign_cnt_q == IGN_L) // R9
    else $error("ignore window not loaded");
  a_glitch_holds: assert property (pressed_q && btn_lvl && hi_cnt_q < GL_L - ONE |=> pressed_q) // R10
    else $error("glitch released press");
  a_release_resets: assert property (!pressed_q |=> press_cnt_q == '0) else $error("timer kept after release"); // R11
  a_notify_pin: assert property (notify_q == NOTIFY_N_OE && NOTIFY_N_O == 1'b0) else $error("open drain misdriven"); // R13

  c_power_on: cover property (!power_q ##1 power_q);
  c_force_off: cover property (force_hit ##1 !power_q);
  c_long_press: cover property (so_evt);
  c_glitch_ride: cover property (pressed_q && btn_lvl ##1 pressed_q && !btn_lvl);
endmodule // pbl_onoff_latch

/* testbench/pbl_button_model.sv */
// Pushbutton and processor side model for the on/off latch bench
`timescale 1ns/100ps
module pbl_button_model
(
  input wire logic clk,
  input wire logic oe,
  input wire logic drv,
  output logic btn_n,
  output logic notify_n,
  output logic [31:0] pulses,
  output logic [31:0] len
);
  int run = 0;
  initial
  begin
    btn_n = 1'b1;
    pulses = 32'h0;
    len = 32'h0;
  end
  // Pull-up on the notify wire
  assign notify_n = oe ? drv : 1'b1;
  // Drive the switch to a level and hold it for k falling edges
  task automatic hold(input logic lvl, input int k);
    btn_n = lvl;
    repeat (k) @(negedge clk);
  endtask
  task automatic press(input int k);
    hold(1'b0, k);
  endtask
  task automatic release_btn(input int k);
    hold(1'b1, k);
  endtask
  // Processor counts notify pulses and their length
  always @(posedge clk)
  begin
    if (notify_n === 1'b0)
      run = run + 1;
    else if (run != 0)
    begin
      pulses = pulses + 1;
      len = run;
      run = 0;
    end
  end
endmodule // pbl_button_model

/* testbench/pbl_onoff_latch_tb_top.sv */
// Self-checking testbench for the pushbutton on/off latch
`timescale 1ns/100ps
module pbl_onoff_latch_tb_top;
  localparam int DB = 20;
  localparam int SO = 200;
  localparam int NC = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic force_n = 1'b1;
  logic pwr;
  logic oe;
  logic drv;
  logic btn_n;
  logic notify_n;
  logic [31:0] pulses;
  logic [31:0] plen;
  int fails = 0;
  int samples_checked = 0;
  int seed = 32'h591C;
  int n;
  int m;
  int t;
  int p0;
  always #50 clk = ~clk;
  pbl_onoff_latch #(.DEBOUNCE_CYC(DB), .SHUTDOWN_CYC(SO), .NOTIFY_CYC(NC), .GLITCH_CYC(4)) DUT (
    .CLK(clk), .RESET_N(rst_n), .BUTTON_IN_N(btn_n), .FORCE_OFF_N(force_n),
    .POWER_EN(pwr), .NOTIFY_N_O(drv), .NOTIFY_N_OE(oe));
  pbl_button_model u_btn (.clk(clk), .oe(oe), .drv(drv), .btn_n(btn_n),
    .notify_n(notify_n), .pulses(pulses), .len(plen));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_pwr(input logic v, output int k);
    k = 0;
    while (pwr !== v && k < 600)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 600)
    begin
      fails++;
      test_done();
    end
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(pwr, 1'b0);
    chk(notify_n, 1'b1);
    force_n = 1'b0;
    repeat (12) @(negedge clk);
    chk(pwr, 1'b0);
    chk(pulses, 32'h0);
    force_n = 1'b1;
    // Bouncing press with short random high glitches
    t = 0;
    for (int i = 0; i < 3; i++)
    begin
      m = 2 + ($unsigned($random(seed)) % 2);
      n = 1 + ($unsigned($random(seed)) % 2);
      u_btn.press(m);
      u_btn.release_btn(n);
      t = t + m + n;
    end
    u_btn.press(0);
    wait_pwr(1'b1, n);
    chk((n + t) >= DB && (n + t) <= DB + 8, 1'b1);
    force_n = 1'b0;
    repeat (12) @(negedge clk);
    force_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(pwr, 1'b1);
    chk(pulses, 32'h1);
    chk(plen, NC);
    u_btn.release_btn(10);
    u_btn.press(DB + 12);
    u_btn.release_btn(10);
    chk(pulses, 32'h2);
    chk(pwr, 1'b1);
    force_n = 1'b0;
    wait_pwr(1'b0, n);
    chk(n <= 8, 1'b1);
    force_n = 1'b1;
    // Two short presses split by a real release
    u_btn.press(DB - 6);
    u_btn.release_btn(8);
    u_btn.press(DB - 6);
    u_btn.release_btn(8);
    chk(pwr, 1'b0);
    chk(pulses, 32'h2);
    // Long hold past shutdown and past the long pulse
    p0 = pulses;
    u_btn.press(0);
    wait_pwr(1'b1, n);
    wait_pwr(1'b0, m);
    chk((n + m) >= SO && (n + m) <= SO + 8, 1'b1);
    u_btn.press(4 * NC + 30);
    chk(plen, 4 * NC);
    chk(pulses, p0 + 2);
    u_btn.release_btn(10);
    // Random force-off noise while power is off
    for (int i = 0; i < 40; i++)
    begin
      n = $random(seed);
      force_n = n[0];
      @(negedge clk);
    end
    force_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(pwr, 1'b0);
    chk(pulses, p0 + 2);
    test_done();
  end
endmodule // pbl_onoff_latch_tb_top
